// File: inc/mnvc_pkg.sv
// package: register map, field layout and timing constants of the mode and nv control block
package mnvc_pkg;
    // register indices; 0x1a is not a multiple of four, so byte address is four times the index
    localparam logic [7:0] MNVC_IDX_MODE = 8'h1a;
    localparam logic [7:0] MNVC_IDX_NVOP = 8'h34;
    localparam logic [7:0] MNVC_IDX_IRQ_STAT = 8'h40;
    localparam logic [7:0] MNVC_IDX_IRQ_MASK = 8'h41;
    localparam logic [7:0] MNVC_IDX_NV_STAT = 8'h42;
    localparam logic [7:0] MNVC_IDX_GAIN = 8'h43;
    localparam logic [7:0] MNVC_IDX_PACE = 8'h44;
    localparam logic [7:0] MNVC_IDX_MODE_REQ = 8'h45;
    localparam int MNVC_ADDR_LSB = 2;

    // mode register fields
    localparam int MNVC_SHD_LO = 5;
    localparam int MNVC_GAP_LO = 2;
    localparam int MNVC_UP_BIT = 1;
    localparam int MNVC_DN_BIT = 0;
    localparam logic [7:0] MNVC_MODE_WMASK = 8'h6f;
    localparam logic [7:0] MNVC_MODE_RESET = 8'h0c;

    // nv control fields
    localparam int MNVC_TRIAL_BIT = 2;
    localparam int MNVC_STORE_BIT = 1;
    localparam int MNVC_RESTORE_BIT = 0;

    // pace register reset: rise pace code 1, fall pace code 0
    localparam logic [7:0] MNVC_PACE_RESET = 8'h10;

    // interrupt status layout
    localparam int MNVC_IRQ_NV_DONE = 0;
    localparam int MNVC_IRQ_GAP_END = 1;
    localparam int MNVC_IRQ_W = 2;

    // timing, ms figures as printed
    localparam int MNVC_CLK_HZ = 10_000_000;
    localparam int MNVC_SHD_MS0 = 10;
    localparam int MNVC_SHD_MS1 = 80;
    localparam int MNVC_SHD_MS2 = 200;
    localparam int MNVC_SHD_MS3 = 400;
    localparam int MNVC_GAP_MS0 = 5;
    localparam int MNVC_GAP_MS1 = 100;
    localparam int MNVC_GAP_MS2 = 200;
    localparam int MNVC_GAP_MS3 = 400;
    localparam int MNVC_CYC_PER_MS = MNVC_CLK_HZ / 1000;

    // mode requests
    typedef enum logic [1:0] {
        MNVC_MODE_NOISE_CANCEL = 2'h0,
        MNVC_MODE_BYPASS = 2'h1,
        MNVC_MODE_MONITOR = 2'h2
    } mnvc_mode_t;

    // headphone selector source
    typedef enum logic [1:0] {
        MNVC_SRC_NONE = 2'h0,
        MNVC_SRC_NOISE_CANCEL = 2'h1,
        MNVC_SRC_BYPASS = 2'h2,
        MNVC_SRC_MONITOR = 2'h3
    } mnvc_src_t;

    // nv sequencer states, one-hot
    typedef enum logic [3:0] {
        MNVC_NV_IDLE = 4'h1,
        MNVC_NV_TRIAL = 4'h2,
        MNVC_NV_STORE = 4'h4,
        MNVC_NV_RESTORE = 4'h8
    } mnvc_nv_state_t;

    // request to the external memory engine
    typedef struct packed {
        logic trial;
        logic store;
        logic restore;
    } mnvc_nv_req_t;

    // answer from the external memory engine
    typedef struct packed {
        logic done;
        logic ok;
    } mnvc_nv_ack_t;
endpackage

// File: src/mnvc_regs.sv
// mode transition and non-volatile operation control register bank, apb slave
`timescale 1ns/10ps
`default_nettype none
module mnvc_regs #(
    parameter int GAIN_W = 8,
    parameter int PACE_UNIT_CYC = 50
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // level control state
    input wire logic i_level_ctrl_on,
    // memory engine
    output mnvc_pkg::mnvc_nv_req_t o_nv_req,
    input wire mnvc_pkg::mnvc_nv_ack_t i_nv_ack,
    // mode sequencer outputs
    output mnvc_pkg::mnvc_src_t o_hp_src,
    output logic [1:0] o_shutdown_sel,
    output logic [GAIN_W-1:0] o_gain,
    // interrupt
    output logic o_irq
);
    import mnvc_pkg::*;

    // pace counter is 23 bits wide, so the unit shifted by 15 must still fit
    if (GAIN_W < 1 || GAIN_W > 24 || PACE_UNIT_CYC < 1 || PACE_UNIT_CYC > 255)
    begin : g_bad_param
        $error("mnvc_regs: unsupported parameter value");
    end

    // gap lengths in cycles per code
    localparam int GAP_C0 = MNVC_GAP_MS0 * MNVC_CYC_PER_MS;
    localparam int GAP_C1 = MNVC_GAP_MS1 * MNVC_CYC_PER_MS;
    localparam int GAP_C2 = MNVC_GAP_MS2 * MNVC_CYC_PER_MS;
    localparam int GAP_C3 = MNVC_GAP_MS3 * MNVC_CYC_PER_MS;

    logic [7:0] mode_q;
    logic [2:0] nvop_q;
    logic trial_pass_flag_q;
    logic nv_done_flag_q;
    logic [MNVC_IRQ_W-1:0] irq_stat_q;
    logic [MNVC_IRQ_W-1:0] irq_mask_q;
    logic [GAIN_W-1:0] gain_tgt_q;
    logic [GAIN_W-1:0] gain_q;
    logic [7:0] pace_q;
    logic [22:0] pace_cnt_q;
    mnvc_mode_t mode_cur_q;
    mnvc_src_t src_q;
    logic [22:0] gap_cnt_q;
    logic gap_busy_q;
    mnvc_nv_state_t nv_state_q;
    logic [31:0] prdata_q;

    // bus decode; every access answers with no wait state
    wire logic [9:0] word_idx = i_paddr[11:MNVC_ADDR_LSB];
    wire logic acc = i_psel && i_penable;
    wire logic wr = acc && i_pwrite;
    wire logic rd_setup = i_psel && !i_penable && !i_pwrite;
    wire logic hit_mode = word_idx == {2'h0, MNVC_IDX_MODE};
    wire logic hit_nvop = word_idx == {2'h0, MNVC_IDX_NVOP};
    wire logic hit_istat = word_idx == {2'h0, MNVC_IDX_IRQ_STAT};
    wire logic hit_imask = word_idx == {2'h0, MNVC_IDX_IRQ_MASK};
    wire logic hit_nvst = word_idx == {2'h0, MNVC_IDX_NV_STAT};
    wire logic hit_gain = word_idx == {2'h0, MNVC_IDX_GAIN};
    wire logic hit_pace = word_idx == {2'h0, MNVC_IDX_PACE};
    wire logic hit_mreq = word_idx == {2'h0, MNVC_IDX_MODE_REQ};
    wire logic hit_any = hit_mode | hit_nvop | hit_istat | hit_imask | hit_nvst | hit_gain
        | hit_pace | hit_mreq;
    wire logic nv_idle = nv_state_q == MNVC_NV_IDLE;

    // trigger writes only start when the sequencer is idle; others are dropped
    wire logic nv_wr = wr && hit_nvop && nv_idle;
    wire logic start_trial = nv_wr && i_pwdata[MNVC_TRIAL_BIT];
    wire logic start_store = nv_wr && !i_pwdata[MNVC_TRIAL_BIT]
        && i_pwdata[MNVC_STORE_BIT];
    wire logic start_rest = nv_wr && !i_pwdata[MNVC_TRIAL_BIT] && !i_pwdata[MNVC_STORE_BIT]
        && i_pwdata[MNVC_RESTORE_BIT];
    wire logic nv_finish = !nv_idle && i_nv_ack.done;

    // gap event and mode request
    wire logic mreq_wr = wr && hit_mreq && !gap_busy_q;
    wire mnvc_mode_t mreq = mnvc_mode_t'(i_pwdata[1:0]);
    wire logic gap_needed = mreq_wr && ((mode_cur_q == MNVC_MODE_NOISE_CANCEL
        && mreq == MNVC_MODE_BYPASS) || (mode_cur_q == MNVC_MODE_BYPASS
        && mreq == MNVC_MODE_MONITOR));
    wire logic gap_end = gap_busy_q && gap_cnt_q == 23'h0;
    wire logic [1:0] gap_code = mode_q[MNVC_GAP_LO +: 2];
    wire logic [22:0] gap_len = gap_code == 2'h0 ? 23'(GAP_C0) : gap_code == 2'h1 ? 23'(GAP_C1)
        : gap_code == 2'h2 ? 23'(GAP_C2) : 23'(GAP_C3);

    // irq events: nv done and gap end; set beats write-one-to-clear
    wire logic [MNVC_IRQ_W-1:0] irq_ev = {gap_end, nv_finish};
    wire logic [MNVC_IRQ_W-1:0] irq_clr = (wr && hit_istat) ?
        i_pwdata[MNVC_IRQ_W-1:0] : '0;

    // gain stepping: instant bits are used alone, level-control enable is not consulted
    wire logic up_inst = mode_q[MNVC_UP_BIT];
    wire logic dn_inst = mode_q[MNVC_DN_BIT];
    wire logic gain_wr = wr && hit_gain;
    wire logic [GAIN_W-1:0] gain_new = i_pwdata[GAIN_W-1:0];
    wire logic rising = gain_tgt_q > gain_q;
    wire logic falling = gain_tgt_q < gain_q;
    wire logic [3:0] pace_sel = rising ? pace_q[7:4] : pace_q[3:0];
    wire logic [22:0] pace_len = 23'(PACE_UNIT_CYC) << pace_sel;
    wire logic step_now = (rising || falling) && pace_cnt_q >= pace_len;
    wire logic unused_ok = i_level_ctrl_on;

    wire logic [31:0] rd_mux = hit_mode ? {24'h0, mode_q}
        : hit_nvop ? {29'h0, nvop_q}
        : hit_istat ? {30'h0, irq_stat_q}
        : hit_imask ? {30'h0, irq_mask_q}
        : hit_nvst ? {30'h0, trial_pass_flag_q, nv_done_flag_q}
        : hit_gain ? 32'(gain_q)
        : hit_pace ? {24'h0, pace_q}
        : hit_mreq ? {28'h0, gap_busy_q, unused_ok & 1'b0, mode_cur_q}
        : 32'h0;

    // register writes; reserved mode bits masked off
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            mode_q <= MNVC_MODE_RESET;
            irq_mask_q <= '0;
            pace_q <= MNVC_PACE_RESET;
        end
        else
        begin
            if (wr && hit_mode)
                mode_q <= i_pwdata[7:0] & MNVC_MODE_WMASK;
            if (wr && hit_imask)
                irq_mask_q <= i_pwdata[MNVC_IRQ_W-1:0];
            if (wr && hit_pace)
                pace_q <= i_pwdata[7:0];
        end
    end

    // irq status, sticky
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
            irq_stat_q <= '0;
        else
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
    end

    // nv sequencer: trigger bit held until the engine answers done
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            nv_state_q <= MNVC_NV_IDLE;
            nvop_q <= 3'h0;
        end
        else
        begin
            case (nv_state_q)
                MNVC_NV_IDLE:
                begin
                    if (start_trial)
                    begin
                        nv_state_q <= MNVC_NV_TRIAL;
                        nvop_q <= 3'(1 << MNVC_TRIAL_BIT);
                    end
                    else if (start_store)
                    begin
                        nv_state_q <= MNVC_NV_STORE;
                        nvop_q <= 3'(1 << MNVC_STORE_BIT);
                    end
                    else if (start_rest)
                    begin
                        nv_state_q <= MNVC_NV_RESTORE;
                        nvop_q <= 3'(1 << MNVC_RESTORE_BIT);
                    end
                end
                MNVC_NV_TRIAL, MNVC_NV_STORE, MNVC_NV_RESTORE:
                begin
                    if (i_nv_ack.done)
                    begin
                        nv_state_q <= MNVC_NV_IDLE;
                        nvop_q <= 3'h0;
                    end
                end
                default:
                begin
                    nv_state_q <= MNVC_NV_IDLE;
                    nvop_q <= 3'h0;
                end
            endcase
        end
    end

    // result flags; trial result does not touch nv_done_flag
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            trial_pass_flag_q <= 1'b0;
            nv_done_flag_q <= 1'b0;
        end
        else if (nv_finish)
        begin
            if (nv_state_q == MNVC_NV_TRIAL)
                trial_pass_flag_q <= i_nv_ack.ok;
            else
                nv_done_flag_q <= i_nv_ack.ok;
        end
    end

    // mode sequencer with silent gap
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            mode_cur_q <= MNVC_MODE_NOISE_CANCEL;
            src_q <= MNVC_SRC_NOISE_CANCEL;
            gap_busy_q <= 1'b0;
            gap_cnt_q <= 23'h0;
        end
        else if (gap_needed)
        begin
            mode_cur_q <= mreq;
            src_q <= MNVC_SRC_NONE;
            gap_busy_q <= 1'b1;
            gap_cnt_q <= gap_len - 23'h1;
        end
        else if (gap_busy_q)
        begin
            gap_cnt_q <= gap_cnt_q - 23'h1;
            if (gap_end)
            begin
                gap_busy_q <= 1'b0;
                src_q <= mode_cur_q == MNVC_MODE_BYPASS ? MNVC_SRC_BYPASS : MNVC_SRC_MONITOR;
            end
        end
        else if (mreq_wr && mreq inside {MNVC_MODE_NOISE_CANCEL, MNVC_MODE_BYPASS, MNVC_MODE_MONITOR})
        begin
            mode_cur_q <= mreq;
            src_q <= mreq == MNVC_MODE_BYPASS ? MNVC_SRC_BYPASS
                : mreq == MNVC_MODE_MONITOR ? MNVC_SRC_MONITOR : MNVC_SRC_NOISE_CANCEL;
        end
    end

    // gain ramp
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            gain_q <= '0;
            gain_tgt_q <= '0;
            pace_cnt_q <= 23'h0;
        end
        else if (gain_wr)
        begin
            gain_tgt_q <= gain_new;
            pace_cnt_q <= 23'h0;
            if ((gain_new > gain_q && up_inst) || (gain_new < gain_q && dn_inst))
                gain_q <= gain_new;
        end
        else if (step_now)
        begin
            pace_cnt_q <= 23'h0;
            gain_q <= rising ? gain_q + 1'b1 : gain_q - 1'b1;
        end
        else if (rising || falling)
            pace_cnt_q <= pace_cnt_q + 23'h1;
    end

    // read data latched in setup phase
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
            prdata_q <= 32'h0;
        else if (rd_setup)
            prdata_q <= rd_mux;
    end

    assign o_prdata = prdata_q;
    assign o_pready = 1'b1;
    assign o_pslverr = acc && !hit_any;
    assign o_nv_req = {nvop_q[MNVC_TRIAL_BIT], nvop_q[MNVC_STORE_BIT],
        nvop_q[MNVC_RESTORE_BIT]};
    assign o_hp_src = src_q;
    assign o_shutdown_sel = mode_q[MNVC_SHD_LO +: 2];
    assign o_gain = gain_q;
    assign o_irq = |(irq_stat_q & irq_mask_q);

    // assertions
    sequence s_gap_start;
        gap_needed;
    endsequence
    sequence s_gap_short;
        gap_needed && gap_len == 23'(GAP_C0);
    endsequence
    property p_gap_arm;
        @(posedge i_mclk) disable iff (!i_reset_n)
        s_gap_start |=> gap_busy_q && o_hp_src == MNVC_SRC_NONE;
    endproperty
    a_gap_arm: assert property (p_gap_arm) else $error("gap not armed");
    property p_gap_silent;
        @(posedge i_mclk) disable iff (!i_reset_n)
        gap_busy_q |-> o_hp_src == MNVC_SRC_NONE;
    endproperty
    a_gap_silent: assert property (p_gap_silent) else $error("source during gap");
    property p_gap_min;
        @(posedge i_mclk) disable iff (!i_reset_n)
        s_gap_short |=> gap_busy_q [*8];
    endproperty
    a_gap_min: assert property (p_gap_min) else $error("gap too short");
    property p_rsv_zero;
        @(posedge i_mclk) disable iff (!i_reset_n)
        mode_q[7] == 1'b0 && mode_q[4] == 1'b0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");
    property p_up_inst;
        @(posedge i_mclk) disable iff (!i_reset_n)
        gain_wr && up_inst && gain_new > gain_q |=> gain_q == $past(gain_new);
    endproperty
    a_up_inst: assert property (p_up_inst) else $error("rise not instant");
    property p_dn_inst;
        @(posedge i_mclk) disable iff (!i_reset_n)
        gain_wr && dn_inst && gain_new < gain_q |=> gain_q == $past(gain_new);
    endproperty
    a_dn_inst: assert property (p_dn_inst) else $error("fall not instant");
    property p_up_ramp;
        @(posedge i_mclk) disable iff (!i_reset_n)
        gain_wr && !up_inst && gain_new > gain_q + 1'b1 |=> gain_q <= $past(gain_q) + 1'b1;
    endproperty
    a_up_ramp: assert property (p_up_ramp) else $error("rise jumped");
    property p_dn_ramp;
        @(posedge i_mclk) disable iff (!i_reset_n)
        gain_wr && !dn_inst && gain_new + 1'b1 < gain_q |=> gain_q + 1'b1 >= $past(gain_q);
    endproperty
    a_dn_ramp: assert property (p_dn_ramp) else $error("fall jumped");
    property p_trial_clear;
        @(posedge i_mclk) disable iff (!i_reset_n)
        nv_state_q == MNVC_NV_TRIAL && i_nv_ack.done |=> nvop_q == 3'h0;
    endproperty
    a_trial_clear: assert property (p_trial_clear) else $error("trial bit stuck");
    property p_store_go;
        @(posedge i_mclk) disable iff (!i_reset_n)
        start_store |=> o_nv_req.store && nvop_q[MNVC_STORE_BIT];
    endproperty
    a_store_go: assert property (p_store_go) else $error("store not started");
    property p_done_flag;
        @(posedge i_mclk) disable iff (!i_reset_n)
        nv_finish && nv_state_q != MNVC_NV_TRIAL |=> nv_done_flag_q == $past(i_nv_ack.ok);
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag wrong");
endmodule // mnvc_regs
`default_nettype wire

// File: bench/mnvc_nv_engine.sv
// behavioural model of the non-volatile memory engine behind the register bank
`timescale 1ns/10ps
`default_nettype none
module mnvc_nv_engine (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // request from the bank and bench controls
    input wire mnvc_pkg::mnvc_nv_req_t i_req,
    input wire logic [7:0] i_delay,
    input wire logic i_ok,
    // answer to the bank
    output mnvc_pkg::mnvc_nv_ack_t o_ack
);
    import mnvc_pkg::*;
    logic [7:0] cnt_q;
    logic fired_q;

    // one done pulse per request after i_delay cycles; ok toggles outside the pulse
    // so that a bank sampling it at the wrong time sees garbage, not a stale value
    always_ff @(posedge i_mclk)
    begin
        o_ack.done <= 1'b0;
        o_ack.ok <= ~o_ack.ok;
        if (!i_reset_n)
        begin
            cnt_q <= 8'h00;
            fired_q <= 1'b0;
            o_ack.ok <= 1'b0;
        end
        else if (i_req == 3'h0)
        begin
            cnt_q <= 8'h00;
            fired_q <= 1'b0;
        end
        else if (!fired_q)
        begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == i_delay)
            begin
                o_ack.done <= 1'b1;
                o_ack.ok <= i_ok;
                fired_q <= 1'b1;
            end
        end
    end
endmodule // mnvc_nv_engine
`default_nettype wire

// File: bench/mnvc_regs_bench.sv
// self-checking bench of the mode and nv control register bank
`timescale 1ns/10ps
`default_nettype none
module mnvc_regs_bench;
    import mnvc_pkg::*;
    logic i_mclk = 1'b0;
    logic i_reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lvl_on = 1'b0;
    mnvc_nv_req_t nv_req;
    mnvc_nv_ack_t nv_ack;
    mnvc_src_t hp_src;
    logic [1:0] shd_sel;
    logic [7:0] gain;
    logic irq;
    logic [7:0] eng_delay = 8'h14;
    logic eng_ok = 1'b0;
    int err_count = 0;
    int n_checks = 0;
    int g_m;
    int n;
    logic ok_m;
    logic [31:0] rd;
    logic er;
    logic [31:0] w;

    // clock at 10 MHz
    always #50 i_mclk = ~i_mclk;

    mnvc_regs #(.GAIN_W(8), .PACE_UNIT_CYC(1)) u_dut (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_level_ctrl_on(lvl_on),
        .o_nv_req(nv_req), .i_nv_ack(nv_ack), .o_hp_src(hp_src),
        .o_shutdown_sel(shd_sel), .o_gain(gain), .o_irq(irq));

    mnvc_nv_engine u_eng (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req(nv_req),
        .i_delay(eng_delay), .i_ok(eng_ok), .o_ack(nv_ack));

    task automatic complete_run();
        if (err_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one apb transfer; waits for pready, only the watchdog ends a dead slave
    task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge i_mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge i_mclk);
        penable <= 1'b1;
        @(posedge i_mclk);
        while (pready !== 1'b1)
        begin
            @(posedge i_mclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [7:0] idx, input logic [31:0] exp, input string msg);
        apb(1'b0, idx, 32'h0);
        chk_val(rd, exp, msg);
    endtask

    // settle after the edge before looking at pins
    task automatic settle(input int c);
        repeat (c) @(posedge i_mclk);
        #1;
    endtask

    // watchdog sized for the 50000-cycle gap plus the register traffic
    initial
    begin
        repeat (80000) @(posedge i_mclk);
        err_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        complete_run();
    end

    initial
    begin
        void'($urandom(67889));
        repeat (12) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        // reset values
        chk_reg(MNVC_IDX_MODE, {24'h0, MNVC_MODE_RESET}, "mode reset");
        chk_reg(MNVC_IDX_NVOP, 32'h0, "nv reset");
        chk_val({30'h0, hp_src}, {30'h0, MNVC_SRC_NOISE_CANCEL}, "src reset");
        chk_reg(8'h20, 32'h0, "unmapped read");
        chk_val({31'h0, er}, 32'h1, "unmapped error");
        // every shutdown code, reserved bits forced high
        for (int c = 0; c < 4; c++)
        begin
            w = {24'h0, 1'b1, 2'(c), 1'b1, 4'($urandom)};
            apb(1'b1, MNVC_IDX_MODE, w);
            chk_reg(MNVC_IDX_MODE, w & {24'h0, MNVC_MODE_WMASK}, "mode readback");
            chk_val({30'h0, shd_sel}, 32'(c), "shutdown code");
        end
        // trial, store, restore with random outcome; irq unmasked for store only, masked for trial and restore
        for (int b = 2; b >= 0; b--)
        begin
            ok_m = 1'($urandom);
            eng_ok <= ok_m;
            eng_delay <= 8'(20 + $urandom % 20);
            apb(1'b1, MNVC_IDX_NVOP, 32'h1 << b);
            settle(2);
            chk_val({29'h0, nv_req}, 32'h1 << b, "nv request");
            chk_reg(MNVC_IDX_NVOP, 32'h1 << b, "nv trigger set");
            n = 0;
            rd = 32'h1;
            // host waits for the trigger to clear before the next one
            while (rd !== 32'h0 && n < 40)
            begin
                apb(1'b0, MNVC_IDX_NVOP, 32'h0);
                n++;
            end
            chk_val(rd, 32'h0, "nv trigger clear");
            apb(1'b0, MNVC_IDX_NV_STAT, 32'h0);
            chk_val({31'h0, (b == 2) ? rd[1] : rd[0]}, {31'h0, ok_m}, "nv result");
            chk_reg(MNVC_IDX_IRQ_STAT, 32'h1, "nv done event");
            apb(1'b1, MNVC_IDX_IRQ_MASK, (b == 1) ? 32'h1 : 32'h0);
            settle(2);
            chk_val({31'h0, irq}, (b == 1) ? 32'h1 : 32'h0, "irq masking");
            apb(1'b1, MNVC_IDX_IRQ_STAT, 32'h1);
            settle(2);
            chk_val({31'h0, irq}, 32'h0, "irq clear");
            chk_reg(MNVC_IDX_IRQ_STAT, 32'h0, "status clear");
        end
        // gain: up, down, up, down; only the opposite direction bit set when ramping
        apb(1'b1, MNVC_IDX_PACE, 32'h0);
        g_m = 0;
        for (int k = 0; k < 4; k++)
        begin
            lvl_on <= 1'($urandom);
            if (k < 2)
                w = (k % 2 == 0) ? 32'h1 : 32'h2;
            else
                w = (k % 2 == 0) ? 32'h2 : 32'h1;
            apb(1'b1, MNVC_IDX_MODE, w);
            g_m = (k % 2 == 0) ? g_m + 20 + int'($urandom % 30) : g_m - 8 - int'($urandom % 8);
            apb(1'b1, MNVC_IDX_GAIN, 32'(g_m));
            settle(3);
            chk_val({31'h0, gain === 8'(g_m)}, 32'(k / 2), "gain jump");
            n = 0;
            while (gain !== 8'(g_m) && n < 200)
            begin
                @(posedge i_mclk);
                #1;
                n++;
            end
            chk_val({24'h0, gain}, 32'(g_m), "gain final");
        end
        // shortest gap, noise-cancel to bypass
        apb(1'b1, MNVC_IDX_MODE, 32'h0);
        apb(1'b1, MNVC_IDX_MODE_REQ, 32'h1);
        settle(3);
        chk_val({30'h0, hp_src}, {30'h0, MNVC_SRC_NONE}, "gap source");
        // a request during the gap is dropped; busy shows in bit 3 beside the bypass code
        apb(1'b1, MNVC_IDX_MODE_REQ, 32'h2);
        chk_reg(MNVC_IDX_MODE_REQ, 32'h9, "gap busy readback");
        // n counts edges since the request landed; look 1 ns after each edge
        n = 9;
        while (hp_src === MNVC_SRC_NONE && n < 60000)
        begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        chk_val({31'h0, n > MNVC_GAP_MS0 * MNVC_CYC_PER_MS - 10}, 32'h1, "gap short");
        chk_val({31'h0, n < MNVC_GAP_MS0 * MNVC_CYC_PER_MS + 10}, 32'h1, "gap long");
        chk_val({30'h0, hp_src}, {30'h0, MNVC_SRC_BYPASS}, "gap target");
        chk_reg(MNVC_IDX_IRQ_STAT, 32'h2, "gap end event");
        // no gap from bypass to noise-cancel, nor from noise-cancel to monitor
        apb(1'b1, MNVC_IDX_MODE_REQ, 32'h0);
        settle(1);
        chk_val({30'h0, hp_src}, {30'h0, MNVC_SRC_NOISE_CANCEL}, "direct source");
        apb(1'b1, MNVC_IDX_MODE_REQ, 32'h2);
        settle(1);
        chk_val({30'h0, hp_src}, {30'h0, MNVC_SRC_MONITOR}, "monitor source");
        complete_run();
    end
endmodule // mnvc_regs_bench
`default_nettype wire
